// >>> rtl/amr_readback.sv
`include "amr_defs.svh"

module amr_readback (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_rd_addr,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_diag_done,
  input  wire logic [7:0] i_diag_impedance,
  input  wire logic [7:0] i_supply_sample,
  input  wire logic       i_playback_active,
  input  wire logic       i_braking,
  input  wire logic       i_period_valid,
  input  wire logic [9:0] i_period_meas,
  input  wire logic       i_period_averaging_disable,
  output logic      [7:0] o_rd_data,
  output logic            o_period_locked
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  amr_pkg::amr_state_t s_q;        // Registered state
  amr_pkg::amr_state_t s_d;        // Next state
  logic [9:0]          avg_period; // Period from the averager
  logic                rd_hi;      // Read of the high period byte
  logic                rd_lo;      // Read of the low period byte
  logic                play_end;   // Waveform just finished
  logic                meas_ok;    // Period sample accepted

  // Read multiplexer over the four bytes
  function automatic logic [7:0] rd_mux(
    input logic [7:0]          addr,
    input amr_pkg::amr_state_t s
  );
    unique case (addr)
      `AMR_ADDR_IMPEDANCE: rd_mux = s.impedance;
      `AMR_ADDR_SUPPLY:    rd_mux = s.supply;
      `AMR_ADDR_PERIOD_HI: rd_mux = {s.rsvd,
                                     s.period[`AMR_HI_MSB:`AMR_HI_LSB]};
      `AMR_ADDR_PERIOD_LO: rd_mux = s.period[7:0];
      default:             rd_mux = `AMR_RST_BYTE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign rd_hi    = i_rd_en && (i_rd_addr == `AMR_ADDR_PERIOD_HI);
  assign rd_lo    = i_rd_en && (i_rd_addr == `AMR_ADDR_PERIOD_LO);
  assign play_end = s_q.play_prev && !i_playback_active;
  // Samples taken while braking are dropped
  assign meas_ok  = i_period_valid && !i_braking;

  assign o_rd_data       = s_q.rd_data;
  assign o_period_locked = s_q.lock;

  // ----------------------------------------------------------------
  // Period averager
  // ----------------------------------------------------------------
  // Input already counts 24.39 us units
  amr_period_avg u_avg (
    .i_clk_sys      (i_clk_sys),
    .i_rst          (i_rst),
    .i_sample_valid (meas_ok),
    .i_sample       (i_period_meas),
    .i_avg_disable  (i_period_averaging_disable),
    .o_period       (avg_period)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.play_prev = i_playback_active;
    // Capture impedance at the end of diagnostics
    if (i_diag_done) begin
      s_d.impedance = i_diag_impedance;
    end
    // Track supply only during playback
    if (i_playback_active) begin
      s_d.supply = i_supply_sample;
    end
    // Follow the averager unless frozen or being frozen now
    if (!s_q.lock && !rd_hi) begin
      s_d.period = avg_period;
    end
    // Freeze on high read; release on low read or waveform end
    if (rd_hi) begin
      s_d.lock = 1'b1;
    end else if (rd_lo) begin
      s_d.lock = 1'b0;
    end else if (play_end) begin
      s_d.lock = 1'b0;
    end
    // Reserved bits of the high byte are writable
    if (i_wr_en && (i_wr_addr == `AMR_ADDR_PERIOD_HI)) begin
      s_d.rsvd = i_wr_data[`AMR_RSVD_MSB:`AMR_RSVD_LSB];
    end
    // Read data is registered and held between reads
    if (i_rd_en) begin
      s_d.rd_data = rd_mux(i_rd_addr, s_q);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence seq_frozen_end;
    s_q.lock && play_end && !rd_hi && !rd_lo;
  endsequence

  sequence seq_hi_then_hold;
    rd_hi ##1 (s_q.lock && !rd_lo && !play_end);
  endsequence

  a_impedance_capture: assert property (
    i_diag_done |=> s_q.impedance == $past(i_diag_impedance))
    else $error("impedance not captured");

  a_impedance_hold: assert property (
    !i_diag_done |=> $stable(s_q.impedance))
    else $error("impedance changed without diagnostics");

  a_supply_track: assert property (
    i_playback_active |=> s_q.supply == $past(i_supply_sample))
    else $error("supply not tracked in playback");

  a_supply_hold: assert property (
    !i_playback_active |=> $stable(s_q.supply))
    else $error("supply changed outside playback");

  a_supply_read: assert property (
    i_rd_en && i_rd_addr == `AMR_ADDR_SUPPLY
      |=> o_rd_data == $past(s_q.supply))
    else $error("supply read wrong");

  a_hi_layout: assert property (
    rd_hi |=> o_rd_data == {$past(s_q.rsvd), $past(s_q.period[9:8])})
    else $error("high byte layout wrong");

  a_freeze_both: assert property (
    seq_hi_then_hold |=> $stable(s_q.period) && s_q.lock)
    else $error("period moved while frozen");

  a_release_low: assert property (
    s_q.lock && rd_lo && !rd_hi |=> !s_q.lock)
    else $error("low read did not release");

  // A high read just after the release freezes again, so it is left out
  a_release_end: assert property (
    seq_frozen_end ##1 !rd_hi
      |-> !s_q.lock ##1 s_q.period == $past(avg_period))
    else $error("waveform end did not release");

  a_track_free: assert property (
    !s_q.lock && !rd_hi |=> s_q.period == $past(avg_period))
    else $error("period not tracking");

  // ----------------------------------------------------------------
  // Checks on read data, reserved storage and the lock
  // ----------------------------------------------------------------
  // High read, one idle cycle, then the low read
  sequence seq_hi_gap_lo;
    rd_hi ##1 (!rd_hi && !rd_lo) ##1 rd_lo;
  endsequence

  // Impedance byte comes back as stored
  a_impedance_read: assert property (
    i_rd_en && i_rd_addr == `AMR_ADDR_IMPEDANCE
      |=> o_rd_data == $past(s_q.impedance))
    else $error("impedance read wrong");

  // Low byte carries period bits 7:0
  a_lo_layout: assert property (
    rd_lo |=> o_rd_data == $past(s_q.period[7:0]))
    else $error("low byte layout wrong");

  // Addresses outside the bank read as zero
  a_unmapped_zero: assert property (
    i_rd_en && (i_rd_addr < `AMR_ADDR_IMPEDANCE ||
                i_rd_addr > `AMR_ADDR_PERIOD_LO)
      |=> o_rd_data == `AMR_RST_BYTE)
    else $error("unmapped read not zero");

  // Read data stands until the next read
  a_rd_hold: assert property (
    !i_rd_en |=> $stable(o_rd_data))
    else $error("read data moved without a read");

  // Reserved bits store what the host writes
  a_rsvd_write: assert property (
    i_wr_en && i_wr_addr == `AMR_ADDR_PERIOD_HI
      |=> s_q.rsvd == $past(i_wr_data[`AMR_RSVD_MSB:`AMR_RSVD_LSB]))
    else $error("reserved bits not written");

  // Reserved bits hold without a write to the high byte
  a_rsvd_hold: assert property (
    !(i_wr_en && i_wr_addr == `AMR_ADDR_PERIOD_HI)
      |=> $stable(s_q.rsvd))
    else $error("reserved bits changed");

  // A high read leaves the lock set, even against a release
  a_hi_wins: assert property (
    rd_hi |=> s_q.lock)
    else $error("high read did not freeze");

  // Only a high read can set the lock
  a_lock_needs_hi: assert property (
    !s_q.lock && !rd_hi |=> !s_q.lock)
    else $error("lock set without a high read");

  // Low byte of a pair is the one frozen at the high read
  a_pair_consistent: assert property (
    seq_hi_gap_lo |=> o_rd_data == $past(s_q.period[7:0], 3))
    else $error("period pair not consistent");

endmodule

// >>> rtl/amr_defs.svh
`ifndef AMR_DEFS_SVH
`define AMR_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AMR_ADDR_IMPEDANCE 8'h03
`define AMR_ADDR_SUPPLY    8'h04
`define AMR_ADDR_PERIOD_HI 8'h05
`define AMR_ADDR_PERIOD_LO 8'h06

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AMR_RST_BYTE   8'h00
`define AMR_RST_PERIOD 10'h000
`define AMR_RST_RSVD   6'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AMR_HI_MSB   9
`define AMR_HI_LSB   8
`define AMR_RSVD_MSB 7
`define AMR_RSVD_LSB 2

// ----------------------------------------------------------------
// Averaging and timing
// ----------------------------------------------------------------
`define AMR_AVG_DEPTH  4
`define AMR_AVG_SHIFT  2
`define AMR_PERIOD_LSB_US 24.39

`endif

// >>> rtl/amr_pkg.sv
package amr_pkg;

  // ----------------------------------------------------------------
  // State of the readback bank
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] impedance;  // Last diagnostics impedance
    logic [7:0] supply;     // Last supply sample
    logic [9:0] period;     // Reported resonance period
    logic [5:0] rsvd;       // Reserved bits of the high byte
    logic       lock;       // Period bytes frozen
    logic       play_prev;  // Playback level one cycle ago
    logic [7:0] rd_data;    // Registered read data
  } amr_state_t;

  // ----------------------------------------------------------------
  // State of the period averager
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0][9:0] taps;  // Last four periods, tap 0 newest
    logic [9:0]      result; // Averaged or last period
  } amr_avg_state_t;

endpackage

// >>> rtl/amr_period_avg.sv
`include "amr_defs.svh"

module amr_period_avg (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_sample_valid,
  input  wire logic [9:0] i_sample,
  input  wire logic       i_avg_disable,
  output logic      [9:0] o_period
);

  amr_pkg::amr_avg_state_t s_q;   // Registered state
  amr_pkg::amr_avg_state_t s_d;   // Next state
  logic [11:0]             sum_w; // Sum of the four taps

  // Sum of four ten-bit taps without overflow
  function automatic logic [11:0] sum4(input logic [3:0][9:0] t);
    sum4 = {2'h0, t[0]} + {2'h0, t[1]} + {2'h0, t[2]} + {2'h0, t[3]};
  endfunction

  assign sum_w    = sum4(s_q.taps);
  assign o_period = s_q.result;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Shift in a new period, taps start from zero
    if (i_sample_valid) begin
      s_d.taps = {s_q.taps[2:0], i_sample};
    end
    // Select last period or four-period mean
    if (i_avg_disable) begin
      s_d.result = s_q.taps[0];
    end else begin
      s_d.result = sum_w[`AMR_AVG_SHIFT +: 10];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_avg_last_only: assert property (
    $past(i_avg_disable) |-> o_period == $past(s_q.taps[0]))
    else $error("last-period report wrong");

  a_avg_mean_four: assert property (
    !$past(i_avg_disable) |-> o_period == $past(sum_w[11:2]))
    else $error("four-period mean wrong");

endmodule

// >>> testbench/amr_host_model.sv
// ----------------------------------------------------------------
// Host processor model: single-byte reads of the readback bank
// ----------------------------------------------------------------
module amr_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rd_data,
  output logic            o_rd_en,
  output logic      [7:0] o_rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    o_rd_en   = 1'b0;
    o_rd_addr = 8'h00;
  end

  // One read: strobe held over one rising edge, data taken one cycle on
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge i_clk_sys);
    o_rd_en   = 1'b1;
    o_rd_addr = addr;
    @(negedge i_clk_sys);
    o_rd_en   = 1'b0;
    o_rd_addr = ~addr;  // Released address shows no stale value
    data      = i_rd_data;
  endtask

  // Period pair: high byte first, low byte in the same playback
  task automatic rd_period(output logic [7:0] hi, output logic [7:0] lo);
    rd(8'h05, hi);
    rd(8'h06, lo);
  endtask
endmodule

// >>> testbench/test_actuator_measurement_readback.sv
module test_actuator_measurement_readback;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  logic       clk, rst, rd_en, wr_en, diag_done, play, pv, avg_dis, brk;
  logic [7:0] rd_addr, wr_addr, wr_data, imp, sup, rd_data, d, lo;
  logic [9:0] meas;
  logic       locked;
  int         err_count;
  int         comparisons;

  // Device under test
  amr_readback i_dut (
    .i_clk_sys(clk), .i_rst(rst), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
    .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .i_diag_done(diag_done), .i_diag_impedance(imp),
    .i_supply_sample(sup), .i_playback_active(play), .i_braking(brk),
    .i_period_valid(pv), .i_period_meas(meas),
    .i_period_averaging_disable(avg_dis), .o_rd_data(rd_data),
    .o_period_locked(locked));

  // Host on the far side of the register port
  amr_host_model i_host (.i_clk_sys(clk), .i_rd_data(rd_data),
    .o_rd_en(rd_en), .o_rd_addr(rd_addr));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Read one byte and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk($sformatf("read %h", a), e, d);
  endtask

  // One write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    wr_en   = 1'b1;
    wr_addr = a;
    wr_data = v;
    @(negedge clk);
    wr_en   = 1'b0;
  endtask

  // New period sample, then wait until it is readable
  task automatic push(input logic [9:0] v);
    @(negedge clk);
    meas = v;
    pv   = 1'b1;
    @(negedge clk);
    pv   = 1'b0;
    meas = ~v;
    repeat (4) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, unmapped read, reserved storage
  task automatic t_reset;
    rc(8'h03, 8'h00);
    rc(8'h04, 8'h00);
    rc(8'h05, 8'h00);
    rc(8'h06, 8'h00);
    rc(8'h07, 8'h00);
    wr(8'h05, 8'hFF);
    rc(8'h05, 8'hFC);
    wr(8'h05, 8'h00);
  endtask

  // Impedance capture, writes to read-only bytes ignored
  task automatic t_imp;
    imp = 8'hA5;
    @(negedge clk);
    diag_done = 1'b1;
    @(negedge clk);
    diag_done = 1'b0;
    imp = 8'h5A;
    wr(8'h03, 8'h00);
    wr(8'h04, 8'hFF);
    rc(8'h03, 8'hA5);
    rc(8'h04, 8'h00);
  endtask

  // Supply sample follows only during playback
  task automatic t_supply;
    sup = 8'h33;
    rc(8'h04, 8'h00);
    play = 1'b1;
    repeat (2) @(negedge clk);
    rc(8'h04, 8'h33);
    play = 1'b0;
    sup  = 8'h44;
    repeat (2) @(negedge clk);
    rc(8'h04, 8'h33);
  endtask

  // High read freezes both bytes until the low read
  task automatic t_lock;
    play = 1'b1;
    push(10'h2C7);
    rc(8'h05, 8'h02);
    chk("locked", 8'h01, {7'h00, locked});
    push(10'h155);
    rc(8'h06, 8'hC7);
    repeat (2) @(negedge clk);
    chk("locked", 8'h00, {7'h00, locked});
    i_host.rd_period(d, lo);
    chk("period hi", 8'h01, d);
    chk("period lo", 8'h55, lo);
  endtask

  // Waveform end releases a pending freeze
  task automatic t_release;
    push(10'h0F0);
    rc(8'h05, 8'h00);
    chk("locked", 8'h01, {7'h00, locked});
    play = 1'b0;
    repeat (2) @(negedge clk);
    chk("locked", 8'h00, {7'h00, locked});
    play = 1'b1;
    push(10'h0A0);
    rc(8'h06, 8'hA0);
    play = 1'b0;
  endtask

  // Average of four over zero-preloaded taps
  task automatic t_avg;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    avg_dis = 1'b0;
    push(10'h200);
    i_host.rd_period(d, lo);
    chk("avg hi", 8'h00, d);
    chk("avg lo", 8'h80, lo);
    push(10'h040);
    push(10'h0C0);
    push(10'h100);
    i_host.rd_period(d, lo);
    chk("avg hi", 8'h01, d);
    chk("avg lo", 8'h00, lo);
  endtask

  // Period samples taken while braking are dropped
  task automatic t_brake;
    push(10'h123);
    brk = 1'b1;
    push(10'h3FF);
    brk = 1'b0;
    i_host.rd_period(d, lo);
    chk("brake hi", 8'h01, d);
    chk("brake lo", 8'h23, lo);
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic summarize;
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cut a hang short after about 4000 cycles
  initial begin
    #100000;
    err_count++;
    summarize;
  end

  initial begin
    rst = 1'b1;
    {wr_en, diag_done, play, pv, brk} = 5'h00;
    {wr_addr, wr_data, imp, sup, meas} = 42'h0;
    avg_dis = 1'b1;
    err_count = 0;
    comparisons = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_imp;
    t_supply;
    t_lock;
    t_release;
    t_brake;
    t_avg;
    summarize;
  end
endmodule
